// file: logic/pwm_defines.svh
// Functional notes
// - counter compared with period and duty continuously
// - mode field selects counter clock, resets zero
// - prescaler divides by two to the exponent
// - optional linear divider a or b
// - left period is x times period times divider
// - center period doubles by up-down count
// - duty register sets waveform duty
// - override forces high and low outputs
// - fault forces outputs low, high or released
// - enable register ignores writes while protected
// - bits 16 to 19 enable fault interrupts
// - bits 0 to 3 enable counter interrupts
// - enable and disable registers are group one
// - analog compare event acts as fault input
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH
`define OFS_IRQ_ENABLE    8'h10
`define OFS_IRQ_DISABLE   8'h14
`define OFS_IRQ_STATUS    8'h1c
`define OFS_IRQ_CLEAR     8'h18
`define OFS_PROTECT       8'h20
`define OFS_OVERRIDE      8'h24
`define OFS_FAULT_CFG     8'h28
`define OFS_CH_BASE       8'h40
`define CH_STRIDE         8'h10
`define OFS_CH_MODE       8'h0
`define OFS_CH_PERIOD     8'h4
`define OFS_CH_DUTY       8'h8
`define OFS_CLOCK_DIV     8'h30
`define FLD_CNT_EV_LSB    0
`define FLD_FLT_EV_LSB    16
`define FLD_MODE_CENTER   4
`define FLD_MODE_EXP_MSB  3
`define PRESCALE_MAX_EXP  4'ha
`define RESET_WORD        32'h0000_0000
`endif

// file: logic/pwm_pkg.sv
package pwm_pkg;
    typedef enum logic [1:0] {fault_low, fault_high, fault_release} fault_mode_t;
    typedef enum logic [1:0] {clk_prescale, clk_div_a, clk_div_b} clk_src_t;
    typedef enum logic {count_up, count_down} count_dir_t;
endpackage

// file: logic/pwm_cfg_if.sv
`timescale 1ns/1ps
interface pwm_cfg_if #(parameter int CW = 16);
    logic [3:0]    exponent;
    logic [1:0]    source;
    logic          center;
    logic [CW-1:0] period;
    logic [CW-1:0] duty;
    logic [7:0]    div_a;
    logic [7:0]    div_b;
    logic          period_event;
    logic          compare_output;
    modport ctrl (output exponent, source, center, period, duty, div_a, div_b,
                  input period_event, compare_output);
    modport chan (input exponent, source, center, period, duty, div_a, div_b,
                  output period_event, compare_output);
endinterface

// file: logic/pwm_channel.sv
`timescale 1ns/1ps
`include "pwm_defines.svh"
module pwm_channel #(
    parameter int CW = 16
) (
    input  wire logic clock_i,
    input  wire logic reset_i,
    pwm_cfg_if.chan   cfg
);
    import pwm_pkg::*;
    typedef struct packed {
        logic [9:0]    pre;
        logic [7:0]    lin;
        logic [CW-1:0] cnt;
        count_dir_t    dir;
        logic          out;
        logic          ev;
    } ch_state_t;
    ch_state_t s_q, s_d;
    logic [10:0] pre_x;
    logic        pre_tick;
    logic [7:0]  lin_max;
    logic        tick;
    // prescaler tick: pre wraps at 2^exponent - 1
    always_comb begin
        pre_x    = (11'h1 << cfg.exponent) - 11'h1;
        pre_tick = (s_q.pre == pre_x[9:0]);
        lin_max  = (cfg.source == clk_div_b) ? cfg.div_b : cfg.div_a;
        tick     = pre_tick && ((cfg.source == clk_prescale) ||
                   (lin_max != 8'h0 && s_q.lin == lin_max - 8'h1));
    end
    // counter, comparator and output; period of center mode counts up then down
    always_comb begin
        s_d    = s_q;
        s_d.ev = 1'b0;
        s_d.pre = pre_tick ? 10'h0 : s_q.pre + 10'h1;
        if (pre_tick && cfg.source != clk_prescale) begin
            s_d.lin = tick ? 8'h0 : s_q.lin + 8'h1;
        end
        if (tick) begin
            if (!cfg.center) begin
                if (s_q.cnt >= cfg.period - 1'b1) begin
                    s_d.cnt = '0;
                    s_d.ev  = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end else if (s_q.dir == count_up) begin
                if (s_q.cnt >= cfg.period - 1'b1) begin
                    s_d.dir = count_down;
                    s_d.cnt = cfg.period;
                    s_d.ev  = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end else begin
                if (s_q.cnt <= 1) begin
                    s_d.dir = count_up;
                    s_d.cnt = '0;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
        end
        s_d.out = (s_q.cnt < cfg.duty);
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign cfg.period_event   = s_q.ev;
    assign cfg.compare_output = s_q.out;
endmodule

// file: logic/pwm_top.sv
`timescale 1ns/1ps
`include "pwm_defines.svh"
module pwm_top #(
    parameter int CH = 4,
    parameter int CW = 16
) (
    input  wire logic          clock_i,
    input  wire logic          reset_i,
    input  wire logic [7:0]    addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic          write_i,
    input  wire logic          read_i,
    output logic [31:0]        rdata_o,
    input  wire logic [CH-1:0] fault_i,
    input  wire logic          analog_compare_event_i,
    input  wire logic          hw_protect_status_group1_i,
    output logic [CH-1:0]      high_side_output_o,
    output logic [CH-1:0]      high_side_oe_o,
    output logic [CH-1:0]      low_side_output_o,
    output logic [CH-1:0]      low_side_oe_o,
    output logic               irq_o
);
    import pwm_pkg::*;
    // status and mask fields hold four channels each, so wider builds are refused
    if (CH < 1 || CH > 4 || CW < 2 || CW > 32) begin : gen_bad_cfg
        $error("pwm_top: unsupported CH or CW");
    end
    typedef struct packed {
        logic [CH-1:0][3:0]    exp;
        logic [CH-1:0][1:0]    src;
        logic [CH-1:0]         ctr;
        logic [CH-1:0][CW-1:0] per;
        logic [CH-1:0][CW-1:0] dty;
        logic [7:0]            div_a;
        logic [7:0]            div_b;
        logic [31:0]           mask;
        logic [31:0]           status;
        logic                  sw_prot;
        logic [CH-1:0]         ovr_en;
        logic [CH-1:0]         ovr_hi;
        logic [CH-1:0]         ovr_lo;
        logic [CH-1:0]         flt_en;
        logic [CH-1:0][1:0]    flt_mode;
        logic [31:0]           rdata;
    } top_state_t;
    top_state_t s_q, s_d;
    logic [CH-1:0] ev;
    logic [CH-1:0] oc;
    logic [CH-1:0] fault_now;
    logic [31:0]   ev_word;
    logic          protected_w;
    logic [7:0]    ch_base;
    int            sel;
    genvar g;
    // one channel per generate entry
    generate
        for (g = 0; g < CH; g++) begin : gen_ch
            pwm_cfg_if #(.CW(CW)) cif ();
            assign cif.exponent = s_q.exp[g];
            assign cif.source   = s_q.src[g];
            assign cif.center   = s_q.ctr[g];
            assign cif.period   = s_q.per[g];
            assign cif.duty     = s_q.dty[g];
            assign cif.div_a    = s_q.div_a;
            assign cif.div_b    = s_q.div_b;
            assign ev[g]        = cif.period_event;
            assign oc[g]        = cif.compare_output;
            pwm_channel #(.CW(CW)) u_ch (
                .clock_i (clock_i),
                .reset_i (reset_i),
                .cfg     (cif.chan)
            );
            // fault is combinational from the pin so it wins without a clock edge
            assign fault_now[g] = s_q.flt_en[g] && (fault_i[g] || analog_compare_event_i);
            always_comb begin
                high_side_oe_o[g] = 1'b1;
                low_side_oe_o[g]  = 1'b1;
                if (fault_now[g]) begin
                    high_side_output_o[g] = (s_q.flt_mode[g] == fault_high);
                    low_side_output_o[g]  = (s_q.flt_mode[g] == fault_high);
                    if (s_q.flt_mode[g] == fault_release) begin
                        high_side_oe_o[g] = 1'b0;
                        low_side_oe_o[g]  = 1'b0;
                    end
                end else if (s_q.ovr_en[g]) begin
                    high_side_output_o[g] = s_q.ovr_hi[g];
                    low_side_output_o[g]  = s_q.ovr_lo[g];
                end else begin
                    high_side_output_o[g] = oc[g];
                    low_side_output_o[g]  = ~oc[g];
                end
            end
        end
    endgenerate
    // events gathered into the status layout
    always_comb begin
        ev_word = '0;
        ev_word[`FLD_CNT_EV_LSB +: CH] = ev;
        ev_word[`FLD_FLT_EV_LSB +: CH] = fault_now;
    end
    assign protected_w = s_q.sw_prot || hw_protect_status_group1_i;
    assign ch_base     = addr_i - `OFS_CH_BASE;
    // offsets past the last channel window must not alias onto channel 0
    assign sel         = (ch_base[7:6] == 2'b00) ? int'(ch_base[5:4]) : CH;
    // register writes, reads and sticky status; a new event beats a clear
    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0;
        if (write_i) begin
            if (addr_i == `OFS_IRQ_ENABLE) begin
                if (!protected_w) begin
                    s_d.mask[`FLD_CNT_EV_LSB +: CH] = s_q.mask[`FLD_CNT_EV_LSB +: CH]
                        | wdata_i[`FLD_CNT_EV_LSB +: CH];
                    s_d.mask[`FLD_FLT_EV_LSB +: CH] = s_q.mask[`FLD_FLT_EV_LSB +: CH]
                        | wdata_i[`FLD_FLT_EV_LSB +: CH];
                end
            end else if (addr_i == `OFS_IRQ_DISABLE) begin
                if (!protected_w) begin
                    s_d.mask = s_q.mask & ~wdata_i;
                end
            end else if (addr_i == `OFS_IRQ_CLEAR) begin
                s_d.status = s_q.status & ~wdata_i;
            end else if (addr_i == `OFS_PROTECT) begin
                s_d.sw_prot = wdata_i[0];
            end else if (addr_i == `OFS_OVERRIDE) begin
                s_d.ovr_en = wdata_i[0 +: CH];
                s_d.ovr_hi = wdata_i[8 +: CH];
                s_d.ovr_lo = wdata_i[16 +: CH];
            end else if (addr_i == `OFS_FAULT_CFG) begin
                s_d.flt_en = wdata_i[0 +: CH];
                for (int i = 0; i < CH; i++) begin
                    s_d.flt_mode[i] = wdata_i[8 + 2*i +: 2];
                end
            end else if (addr_i == `OFS_CLOCK_DIV) begin
                s_d.div_a = wdata_i[7:0];
                s_d.div_b = wdata_i[15:8];
            end else if (addr_i >= `OFS_CH_BASE && sel < CH) begin
                if (ch_base[3:0] == `OFS_CH_MODE) begin
                    s_d.exp[sel] = (wdata_i[3:0] > `PRESCALE_MAX_EXP) ?
                                   `PRESCALE_MAX_EXP : wdata_i[3:0];
                    s_d.ctr[sel] = wdata_i[`FLD_MODE_CENTER];
                    s_d.src[sel] = wdata_i[9:8];
                end else if (ch_base[3:0] == `OFS_CH_PERIOD) begin
                    s_d.per[sel] = wdata_i[CW-1:0];
                end else if (ch_base[3:0] == `OFS_CH_DUTY) begin
                    s_d.dty[sel] = wdata_i[CW-1:0];
                end
            end
        end
        s_d.status = s_d.status | ev_word;
        if (read_i) begin
            if (addr_i == `OFS_IRQ_STATUS) begin
                s_d.rdata = s_q.status;
            end else if (addr_i == `OFS_PROTECT) begin
                s_d.rdata = {30'h0, hw_protect_status_group1_i, s_q.sw_prot};
            end else if (addr_i >= `OFS_CH_BASE && sel < CH) begin
                if (ch_base[3:0] == `OFS_CH_MODE) begin
                    s_d.rdata = {22'h0, s_q.src[sel], 3'h0, s_q.ctr[sel], s_q.exp[sel]};
                end else if (ch_base[3:0] == `OFS_CH_PERIOD) begin
                    s_d.rdata[CW-1:0] = s_q.per[sel];
                end else if (ch_base[3:0] == `OFS_CH_DUTY) begin
                    s_d.rdata[CW-1:0] = s_q.dty[sel];
                end
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign rdata_o = s_q.rdata;
    assign irq_o   = |(s_q.status & s_q.mask);
endmodule

// file: bench/pwm_top_chk.sv
`timescale 1ns/1ps
module pwm_top_chk #(
    parameter int CH = 4,
    parameter int CW = 16
) (
    input wire logic          clock_i,
    input wire logic          reset_i,
    input wire logic [7:0]    addr_i,
    input wire logic [31:0]   wdata_i,
    input wire logic          write_i,
    input wire logic          read_i,
    input wire logic [31:0]   rdata_o,
    input wire logic [CH-1:0] fault_i,
    input wire logic          analog_compare_event_i,
    input wire logic          hw_protect_status_group1_i,
    input wire logic [CH-1:0] high_side_output_o,
    input wire logic [CH-1:0] high_side_oe_o,
    input wire logic [CH-1:0] low_side_output_o,
    input wire logic [CH-1:0] low_side_oe_o,
    input wire logic          irq_o
);
    logic          lock_q;
    logic [CH-1:0] flt;
    // shadow of the software lock, so mask writes can be judged from outside
    always_ff @(posedge clock_i) begin
        if (reset_i) lock_q <= 1'b0;
        else if (write_i && addr_i == 8'h20) lock_q <= wdata_i[0];
    end
    assign flt = fault_i | {CH{analog_compare_event_i}};
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    chk_rdata_idle:
        assert property (!$past(read_i) |-> rdata_o == 32'h0) else $error("stray read data");
    chk_reset_state:
        assert property ($past(reset_i) |-> !irq_o && high_side_oe_o == {CH{1'b1}})
        else $error("bad state after reset");
    chk_enable_wo:
        assert property (read_i && addr_i == 8'h10 |=> rdata_o == 32'h0)
        else $error("enable register readable");
    chk_unmapped_read:
        assert property (read_i && addr_i == 8'h04 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_hw_lock_read:
        assert property (read_i && addr_i == 8'h20 |=>
            rdata_o[1] == $past(hw_protect_status_group1_i)) else $error("lock status wrong");
    chk_mask_clear:
        assert property (write_i && addr_i == 8'h14 && wdata_i == 32'h000f000f && !lock_q
            && !hw_protect_status_group1_i |=> !irq_o) else $error("irq after disable");
    chk_oe_pair:
        assert property (high_side_oe_o == low_side_oe_o) else $error("enables split");
    chk_release_cause:
        assert property ((~high_side_oe_o & ~flt & ~$past(flt)) == '0)
        else $error("release without fault");
endmodule
bind pwm_top pwm_top_chk #(.CH(CH), .CW(CW)) chk_i (.clock_i(clock_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .fault_i(fault_i), .analog_compare_event_i(analog_compare_event_i),
    .hw_protect_status_group1_i(hw_protect_status_group1_i),
    .high_side_output_o(high_side_output_o), .high_side_oe_o(high_side_oe_o),
    .low_side_output_o(low_side_output_o), .low_side_oe_o(low_side_oe_o), .irq_o(irq_o));

// file: bench/pwm_stage_model.sv
`timescale 1ns/1ps
module pwm_stage_model (
    input  wire logic  clock_i,
    input  wire logic  gate_i,
    input  wire logic  gate_oe_i,
    output logic [15:0] period_o,
    output logic [15:0] high_o
);
    logic [15:0] cnt_q = 16'h0;
    logic [15:0] hcnt_q = 16'h0;
    logic        prev_q = 1'b0;
    logic        gate;
    // a released gate input sinks through its pull-down, so the switch is off
    assign gate = gate_oe_i & gate_i;
    // measure from one switch-on to the next
    always_ff @(posedge clock_i) begin
        prev_q <= gate;
        if (gate && !prev_q) begin
            period_o <= cnt_q;
            high_o <= hcnt_q;
            cnt_q <= 16'h1;
            hcnt_q <= 16'h1;
        end else begin
            cnt_q <= cnt_q + 16'h1;
            hcnt_q <= hcnt_q + {15'h0, gate};
        end
    end
endmodule

// file: bench/test_pwm_channel_comparator.sv
`timescale 1ns/1ps
module test_pwm_channel_comparator;
    logic        clock_i = 1'b0, reset_i = 1'b1, write_i = 1'b0, read_i = 1'b0;
    logic        hwp = 1'b0, ace = 1'b0, irq;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  flt = 4'h0, hs, hso, ls, lso;
    logic [15:0] per, hi;
    logic [31:0] mode [4] = '{32'h0, 32'h1, 32'h10, 32'h100};
    logic [15:0] eper [4] = '{16'd8, 16'd16, 16'd16, 16'd24};
    logic [15:0] ehi [4] = '{16'd3, 16'd6, 16'd5, 16'd9};
    logic [3:0]  fe [3] = '{4'b0011, 4'b1111, 4'b0000};
    logic [3:0]  fm [3] = '{4'hf, 4'hf, 4'h3};
    int          bad_count = 0, tests_run = 0;
    pwm_top dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata), .fault_i(flt),
        .analog_compare_event_i(ace), .hw_protect_status_group1_i(hwp),
        .high_side_output_o(hs), .high_side_oe_o(hso), .low_side_output_o(ls),
        .low_side_oe_o(lso), .irq_o(irq));
    pwm_stage_model stage (.clock_i(clock_i), .gate_i(hs[0]), .gate_oe_i(hso[0]),
        .period_o(per), .high_o(hi));
    initial forever #5 clock_i = ~clock_i;
    task chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one strobe cycle, then one idle edge so strobes never double up
    task wr(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
        addr <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        @(negedge clock_i);
        chk("rdata", rdata & m, e);
        @(posedge clock_i);
    endtask
    task pins(logic [3:0] m, logic [3:0] e);
        @(negedge clock_i);
        chk("pins", {28'h0, {hs[0], ls[0], hso[0], lso[0]} & m}, {28'h0, e});
        @(posedge clock_i);
    endtask
    task irq_is(logic e);
        repeat (30) @(posedge clock_i);
        @(negedge clock_i);
        chk("irq", {31'h0, irq}, {31'h0, e});
        @(posedge clock_i);
    endtask
    // watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        pins(4'hf, 4'b0111);
        rd(8'h40, 32'hffffffff, 32'h0);
        wr(8'h44, 32'h8);
        wr(8'h48, 32'h3);
        wr(8'h30, 32'h3);
        // prescaler, doubled prescaler, center mode and linear divider
        for (int i = 0; i < 4; i++) begin
            wr(8'h40, mode[i]);
            repeat (80) @(posedge clock_i);
            chk("period", {16'h0, per}, {16'h0, eper[i]});
            chk("high", {16'h0, hi}, {16'h0, ehi[i]});
        end
        wr(8'h40, 32'h0);
        wr(8'h18, 32'h000f000f);
        irq_is(1'b0);
        wr(8'h20, 32'h1);
        wr(8'h10, 32'h1);
        irq_is(1'b0);
        wr(8'h20, 32'h0);
        hwp <= 1'b1;
        wr(8'h10, 32'h1);
        irq_is(1'b0);
        rd(8'h20, 32'h3, 32'h2);
        hwp <= 1'b0;
        wr(8'h10, 32'h1);
        irq_is(1'b1);
        rd(8'h1c, 32'h1, 32'h1);
        wr(8'h10, 32'h0);
        irq_is(1'b1);
        rd(8'h10, 32'hffffffff, 32'h0);
        rd(8'h04, 32'hffffffff, 32'h0);
        wr(8'h14, 32'h000f000f);
        wr(8'h18, 32'h000f000f);
        wr(8'h10, 32'h10000);
        wr(8'h24, 32'h101);
        pins(4'hf, 4'b1011);
        // each fault mode over the override; the first one comes from the comparator
        for (int m = 0; m < 3; m++) begin
            wr(8'h28, 32'h1 | (m << 8));
            ace <= (m == 0);
            flt[0] <= (m != 0);
            @(posedge clock_i);
            pins(fm[m], fe[m]);
            @(negedge clock_i);
            chk("fault irq", {31'h0, irq}, 32'h1);
            @(posedge clock_i);
            ace <= 1'b0;
            flt[0] <= 1'b0;
            wr(8'h18, 32'h10000);
            @(negedge clock_i);
            chk("irq clear", {31'h0, irq}, 32'h0);
            @(posedge clock_i);
        end
        report_and_stop();
    end
endmodule
